// ===== inc/cbs_pkg.sv
// constants, cycle kinds and state layout for the bus-cycle sequencer
package cbs_pkg;

  // operations the core may hand to the sequencer
  localparam logic [3:0] OP_TEST_REG   = 4'h0;
  localparam logic [3:0] OP_TEST_IMM   = 4'h1;
  localparam logic [3:0] OP_TEST_HL    = 4'h2;
  localparam logic [3:0] OP_TEST_PORT  = 4'h3;
  localparam logic [3:0] OP_NMI        = 4'h4;
  localparam logic [3:0] OP_L0_RESTART = 4'h5;
  localparam logic [3:0] OP_L0_CALL    = 4'h6;
  localparam logic [3:0] OP_L0_MODE1   = 4'h7;
  localparam logic [3:0] OP_L0_MODE2   = 4'h8;
  localparam logic [3:0] OP_INT_VEC    = 4'h9;

  // t-states per machine cycle
  localparam logic [2:0] CYC_IDLE = 3'h1;
  localparam logic [2:0] CYC_BUS  = 3'h3;
  localparam logic [2:0] CYC_ACK1 = 3'h4;
  localparam logic [2:0] CYC_ACK2 = 3'h5;

  // strobes {halt,opening,fetch,ioreq,memreq,wr,rd}, all active low
  localparam logic [6:0] STB_FETCH1 = 7'h4a;
  localparam logic [6:0] STB_FETCH2 = 7'h6a;
  localparam logic [6:0] STB_MEMRD  = 7'h7a;
  localparam logic [6:0] STB_IORD_H = 7'h76;
  localparam logic [6:0] STB_IORD_L = 7'h66;
  localparam logic [6:0] STB_ACK    = 7'h47;
  localparam logic [6:0] STB_DUMMY  = 7'h5f;
  localparam logic [6:0] STB_WRITE  = 7'h79;
  localparam logic [6:0] STB_IDLE   = 7'h7f;

  localparam logic [7:0]  IO_ADDR_HIGH = 8'h00;
  localparam logic [15:0] ADDR_IDLE    = 16'h0000;

  typedef enum logic [13:0] {
    K_NONE   = 14'h0001,
    K_FETCH1 = 14'h0002,
    K_FETCH2 = 14'h0004,
    K_RD_PC  = 14'h0008,
    K_RD_HL  = 14'h0010,
    K_IO_RD  = 14'h0020,
    K_NMI_F  = 14'h0040,
    K_ACK1   = 14'h0080,
    K_ACK2   = 14'h0100,
    K_DUMMY  = 14'h0200,
    K_IDLE   = 14'h0400,
    K_WR_H   = 14'h0800,
    K_WR_L   = 14'h1000,
    K_RD_TAB = 14'h2000
  } cbs_kind_e;

  typedef struct packed {
    cbs_kind_e   kind;
    logic [2:0]  step;
    logic [2:0]  tcnt;
    logic [3:0]  op;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] hl;
    logic [7:0]  c;
    logic [7:0]  i;
    logic [7:0]  vec;
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic        compat;
    logic        tab;
    logic [15:0] addr;
    logic [7:0]  dout;
    logic        doe;
    logic [6:0]  strb;
    logic        done;
    logic        pc_load;
    logic        smp;
    logic        lock;
  } cbs_state_s;

endpackage : cbs_pkg

// ===== rtl/cbs_bus_seq.sv
// bus-cycle sequencer for test instructions and interrupt responses
//
// Overview of operation
// RULE1: idle states drive a dummy address, float data and hold strobes off.
// RULE2: interrupts are only sampled at the end of a test instruction.
// RULE3: once an interrupt response starts the bus stays locked to it.
// RULE4: the fetch marker in an i/o read follows the i/o compatibility bit.
// RULE5: every instruction opens with two three-state fetches.
// RULE6: the register test adds one idle state and no bus access.
// RULE7: the immediate test reads its operand at the next program address.
// RULE8: the indirect test idles once then reads at the HL address.
// RULE9: the port test reads i/o at C with zero on the upper address byte.
// RULE10: each interrupt response pushes the return address high then low.
// RULE11: a non-maskable response does a dummy fetch and two idle states.
// RULE12: a mode-0 restart acknowledge has one wait and two idle states.
// RULE13: a mode-0 call acknowledge reads two address bytes then pushes.
// RULE14: a mode-1 acknowledge has two waits and then pushes at once.
// RULE15: a mode-2 acknowledge takes a vector, pushes, then reads a table.
// RULE16: vectored interrupts use a dummy cycle with only the opening flag.
// RULE17: after the table or call reads the new address loads the counter.
`timescale 1ns/1ps
module cbs_bus_seq
  import cbs_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // operation request from the core
  input  wire logic        START,
  input  wire logic [3:0]  OP,
  input  wire logic [15:0] PC_IN,
  input  wire logic [15:0] SP_IN,
  input  wire logic [15:0] HL_IN,
  input  wire logic [7:0]  C_IN,
  input  wire logic [7:0]  I_IN,
  input  wire logic [7:0]  VEC_IN,
  input  wire logic        IO_COMPAT_BIT,
  // data bus pins
  input  wire logic [7:0]  DATA_IN,
  output logic      [7:0]  DATA_OUT,
  output logic             DATA_OE,
  // address and strobes
  output logic      [15:0] ADDR,
  output logic             RD_N,
  output logic             WR_N,
  output logic             MEMORY_REQUEST_N,
  output logic             IO_REQUEST_N,
  output logic             FETCH_CYCLE_MARKER_N,
  output logic             OPENING_CYCLE_FLAG_N,
  output logic             HALT_N,
  // status to the core
  output logic             BUSY,
  output logic             DONE,
  output logic             PC_LOAD,
  output logic      [15:0] PC_OUT,
  output logic      [7:0]  OPERAND,
  output logic      [7:0]  ACK_BYTE,
  output logic             IRQ_SAMPLE,
  output logic             BUS_LOCK
);

  //////////////////////////////////////////////////////////////////////////
  logic [7:0] din_sync;
  cbs_sync #(.W(8)) u_din_sync (
    .clk   (CLK),
    .rst_b (RST_B),
    .d     (DATA_IN),
    .q     (din_sync)
  );

  cbs_state_s s_reg;
  cbs_state_s s_next;

  //////////////////////////////////////////////////////////////////////////
  // machine-cycle list for each operation; K_NONE ends it
  function automatic cbs_kind_e seq_kind(input logic [3:0] op,
                                         input logic [2:0] idx);
    cbs_kind_e k;
    k = K_NONE;
    case (op)
      OP_TEST_REG, OP_TEST_IMM, OP_TEST_HL, OP_TEST_PORT: begin
        case (idx)
          3'h0: k = K_FETCH1; // [RULE5]
          3'h1: k = K_FETCH2; // [RULE5]
          3'h2: begin
            if (op == OP_TEST_REG || op == OP_TEST_HL) k = K_IDLE; // [RULE6]
            else k = K_RD_PC; // [RULE7]
          end
          3'h3: begin
            if (op == OP_TEST_HL) k = K_RD_HL; // [RULE8]
            else if (op == OP_TEST_PORT) k = K_IO_RD; // [RULE9]
            else k = K_NONE;
          end
          default: k = K_NONE;
        endcase
      end
      OP_NMI, OP_L0_RESTART: begin
        case (idx)
          3'h0: k = (op == OP_NMI) ? K_NMI_F : K_ACK1; // [RULE11] [RULE12]
          3'h1: k = K_IDLE;
          3'h2: k = K_IDLE;
          3'h3: k = K_WR_H; // [RULE10]
          3'h4: k = K_WR_L; // [RULE10]
          default: k = K_NONE;
        endcase
      end
      OP_L0_CALL: begin
        case (idx)
          3'h0: k = K_ACK2; // [RULE13]
          3'h1: k = K_RD_PC;
          3'h2: k = K_RD_PC;
          3'h3: k = K_IDLE;
          3'h4: k = K_WR_H;
          3'h5: k = K_WR_L;
          default: k = K_NONE;
        endcase
      end
      OP_L0_MODE1: begin
        case (idx)
          3'h0: k = K_ACK2; // [RULE14]
          3'h1: k = K_WR_H;
          3'h2: k = K_WR_L;
          default: k = K_NONE;
        endcase
      end
      OP_L0_MODE2, OP_INT_VEC: begin
        case (idx)
          3'h0: k = op == OP_L0_MODE2 ? K_ACK2 : K_DUMMY; // [RULE15] [RULE16]
          3'h1: k = K_IDLE;
          3'h2: k = K_WR_H;
          3'h3: k = K_WR_L;
          3'h4: k = K_RD_TAB;
          3'h5: k = K_RD_TAB;
          default: k = K_NONE;
        endcase
      end
      default: k = K_NONE;
    endcase
    return k;
  endfunction : seq_kind

  function automatic logic [2:0] cyc_len(input cbs_kind_e k);
    case (k)
      K_IDLE:          cyc_len = CYC_IDLE;
      K_ACK1:          cyc_len = CYC_ACK1; // [RULE12]
      K_ACK2, K_DUMMY: cyc_len = CYC_ACK2; // [RULE14] [RULE16]
      default:         cyc_len = CYC_BUS;
    endcase
  endfunction : cyc_len

  function automatic logic [6:0] strobes(input cbs_kind_e k,
                                         input logic compat);
    case (k)
      K_FETCH1, K_NMI_F:        strobes = STB_FETCH1; // [RULE5] [RULE11]
      K_FETCH2:                 strobes = STB_FETCH2; // [RULE5]
      K_RD_PC, K_RD_HL, K_RD_TAB: strobes = STB_MEMRD; // [RULE7]
      K_IO_RD:  strobes = compat ? STB_IORD_H : STB_IORD_L; // [RULE4] [RULE9]
      K_ACK1, K_ACK2:           strobes = STB_ACK; // [RULE12]
      K_DUMMY:                  strobes = STB_DUMMY; // [RULE16]
      K_WR_H, K_WR_L:           strobes = STB_WRITE; // [RULE10]
      default:                  strobes = STB_IDLE; // [RULE1]
    endcase
  endfunction : strobes

  //////////////////////////////////////////////////////////////////////////
  logic       last_t;
  logic       is_test;
  logic       is_int;
  cbs_kind_e  k_after;

  always_comb begin
    s_next         = s_reg;
    s_next.done    = 1'b0;
    s_next.pc_load = 1'b0;
    s_next.smp     = 1'b0;
    last_t  = (s_reg.tcnt == cyc_len(s_reg.kind) - 3'h1);
    is_test = (s_reg.op <= OP_TEST_PORT);
    k_after = seq_kind(s_reg.op, s_reg.step + 3'h1);
    is_int  = 1'b0;
    if (s_reg.kind == K_NONE) begin
      // a start while busy is dropped; the core waits on BUSY
      if (START) begin
        s_next.op   = OP;
        s_next.pc   = PC_IN;
        s_next.sp   = SP_IN;
        s_next.hl   = HL_IN;
        s_next.c    = C_IN;
        s_next.i    = I_IN;
        s_next.vec  = VEC_IN;
        s_next.compat = IO_COMPAT_BIT;
        s_next.tab  = 1'b0;
        s_next.step = 3'h0;
        s_next.tcnt = 3'h0;
        s_next.kind = seq_kind(OP, 3'h0);
      end
    end else if (!last_t) begin
      s_next.tcnt = s_reg.tcnt + 3'h1;
    end else begin
      s_next.tcnt = 3'h0;
      s_next.step = s_reg.step + 3'h1;
      s_next.kind = k_after;
      case (s_reg.kind)
        K_FETCH1, K_FETCH2: s_next.pc = s_reg.pc + 16'h0001; // [RULE5]
        K_RD_PC: begin
          s_next.pc = s_reg.pc + 16'h0001; // [RULE7] [RULE13]
          s_next.hi = din_sync;
          s_next.lo = s_reg.hi;
        end
        K_RD_HL, K_IO_RD: s_next.hi = din_sync; // [RULE8] [RULE9]
        K_ACK1: s_next.vec = din_sync; // [RULE12]
        K_ACK2: begin
          if (s_reg.op != OP_L0_MODE1) s_next.vec = din_sync; // [RULE14]
        end
        K_RD_TAB: begin
          s_next.hi  = din_sync; // [RULE15]
          s_next.lo  = s_reg.hi;
          s_next.tab = 1'b1;
        end
        default: s_next.tcnt = 3'h0;
      endcase
      if (k_after == K_NONE) begin
        s_next.done = 1'b1;
        // interrupts are looked at only where an instruction ends
        s_next.smp  = is_test; // [RULE2]
        if (s_reg.op == OP_L0_CALL || s_reg.op == OP_L0_MODE2 ||
            s_reg.op == OP_INT_VEC) begin
          s_next.pc      = {s_next.hi, s_next.lo}; // [RULE17]
          s_next.pc_load = 1'b1; // [RULE17]
        end
      end
    end
    // pin values follow the cycle being entered
    s_next.strb = strobes(s_next.kind, s_next.compat);
    s_next.doe  = (s_next.kind == K_WR_H) || (s_next.kind == K_WR_L);
    s_next.dout = (s_next.kind == K_WR_H) ? s_next.pc[15:8]
                                          : s_next.pc[7:0]; // [RULE10]
    case (s_next.kind)
      K_FETCH1, K_FETCH2, K_RD_PC, K_NMI_F, K_ACK1, K_ACK2, K_DUMMY:
        s_next.addr = s_next.pc;
      K_RD_HL: s_next.addr = s_next.hl; // [RULE8]
      K_IO_RD: s_next.addr = {IO_ADDR_HIGH, s_next.c}; // [RULE9]
      K_WR_H:  s_next.addr = s_next.sp - 16'h0001; // [RULE10]
      K_WR_L:  s_next.addr = s_next.sp - 16'h0002; // [RULE10]
      K_RD_TAB: s_next.addr = {s_next.i,
                               s_next.vec + {7'h00, s_next.tab}}; // [RULE15]
      default: s_next.addr = ADDR_IDLE; // [RULE1]
    endcase
    is_int = (s_next.op >= OP_NMI) && (s_next.op <= OP_INT_VEC);
    // dma, refresh and bus release wait until the response is over
    s_next.lock = (s_next.kind != K_NONE) && is_int; // [RULE3]
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      s_reg      <= '0;
      s_reg.kind <= K_NONE;
      s_reg.strb <= STB_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  assign ADDR                 = s_reg.addr;
  assign DATA_OUT             = s_reg.dout;
  assign DATA_OE              = s_reg.doe; // [RULE1]
  assign RD_N                 = s_reg.strb[0];
  assign WR_N                 = s_reg.strb[1];
  assign MEMORY_REQUEST_N     = s_reg.strb[2];
  assign IO_REQUEST_N         = s_reg.strb[3];
  assign FETCH_CYCLE_MARKER_N = s_reg.strb[4];
  assign OPENING_CYCLE_FLAG_N = s_reg.strb[5];
  assign HALT_N               = s_reg.strb[6];
  assign BUSY                 = (s_reg.kind != K_NONE);
  assign DONE                 = s_reg.done;
  assign PC_LOAD              = s_reg.pc_load;
  assign PC_OUT               = s_reg.pc;
  assign OPERAND              = s_reg.hi;
  assign ACK_BYTE             = s_reg.vec;
  assign IRQ_SAMPLE           = s_reg.smp;
  assign BUS_LOCK             = s_reg.lock;

endmodule : cbs_bus_seq

// ===== rtl/cbs_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module cbs_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // pin side and synchronised side
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : cbs_sync

// ===== verification/cbs_bus_partner.sv
// memory, port and interrupt source on the far side of the bus
`timescale 1ns/1ps
module cbs_bus_partner (
  // clock
  input  wire logic        clk,
  // bus from the sequencer
  input  wire logic [15:0] addr,
  input  wire logic        rd_n,
  input  wire logic        io_request_n,
  input  wire logic        fetch_cycle_marker_n,
  // byte handed over in an acknowledge
  input  wire logic [7:0]  ack_val,
  // data towards the sequencer
  output logic      [7:0]  data
);
  logic [7:0] junk_reg = 8'h00;
  // a released bus must never look like the last byte read
  always @(posedge clk) junk_reg <= junk_reg + 8'h5b;
  always_comb begin
    if (!rd_n) data = addr[7:0] ^ addr[15:8] ^ 8'h3c;
    else if (!io_request_n && !fetch_cycle_marker_n)
      data = ack_val;
    else data = junk_reg;
  end
endmodule : cbs_bus_partner

// ===== verification/cbs_bus_seq_asserts.sv
// assertion checker for the bus-cycle sequencer
`timescale 1ns/1ps
module cbs_bus_seq_asserts
  import cbs_pkg::*;
(
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST_B,
  // request
  input wire logic        START,
  input wire logic [3:0]  OP,
  input wire logic [15:0] PC_IN,
  input wire logic        IO_COMPAT_BIT,
  // bus
  input wire logic [15:0] ADDR,
  input wire logic        DATA_OE,
  input wire logic        RD_N,
  input wire logic        WR_N,
  input wire logic        MEMORY_REQUEST_N,
  input wire logic        IO_REQUEST_N,
  input wire logic        FETCH_CYCLE_MARKER_N,
  input wire logic        OPENING_CYCLE_FLAG_N,
  input wire logic        HALT_N,
  // status
  input wire logic        BUSY,
  input wire logic        DONE,
  input wire logic        PC_LOAD,
  input wire logic        IRQ_SAMPLE,
  input wire logic        BUS_LOCK
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  logic [6:0] stb;
  logic       go;
  logic       compat_reg;
  assign stb = {HALT_N, OPENING_CYCLE_FLAG_N, FETCH_CYCLE_MARKER_N,
                IO_REQUEST_N, MEMORY_REQUEST_N, WR_N, RD_N};
  assign go = START && !BUSY;
  // the bit may move during a sequence, so follow the latched copy
  always_ff @(posedge CLK) begin
    if (!RST_B) compat_reg <= 1'b0;
    else if (go) compat_reg <= IO_COMPAT_BIT;
  end
////////////////////////////////////////
  property p_idle;
    BUSY && stb == 7'h7f |-> !DATA_OE && ADDR == 16'h0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle state drives the bus");
  property p_smp;
    IRQ_SAMPLE |-> DONE && !$past(BUS_LOCK);
  endproperty
  a_smp: assert property (p_smp)
    else $error("sampling outside a test op end");
  property p_lock;
    (!IO_REQUEST_N && RD_N) || !WR_N || stb == 7'h5f |-> BUS_LOCK;
  endproperty
  a_lock: assert property (p_lock)
    else $error("interrupt cycle without bus lock");
  property p_io;
    !IO_REQUEST_N && !RD_N |-> FETCH_CYCLE_MARKER_N == compat_reg
      && MEMORY_REQUEST_N && ADDR[15:8] == 8'h00;
  endproperty
  a_io: assert property (p_io)
    else $error("bad port read cycle");
  property p_reg;
    go && OP == 4'h0 |=> (stb == 7'h4a)[*3] ##1 (stb == 7'h6a)[*3]
      ##1 stb == 7'h7f ##1 DONE && IRQ_SAMPLE;
  endproperty
  a_reg: assert property (p_reg)
    else $error("bad register test sequence");
  property p_push;
    !WR_N && $past(WR_N) |-> DATA_OE
      ##3 (!WR_N && ADDR == $past(ADDR, 3) - 16'h1)[*3] ##1 WR_N;
  endproperty
  a_push: assert property (p_push)
    else $error("bad return address push");
  property p_nmi;
    go && OP == 4'h4 |=> stb == 7'h4a && ADDR == $past(PC_IN)
      ##1 (stb == 7'h4a)[*2] ##1 (stb == 7'h7f)[*2]
      ##1 (stb == 7'h79)[*6] ##1 DONE;
  endproperty
  a_nmi: assert property (p_nmi)
    else $error("bad non-maskable response");
  property p_vec;
    go && OP == 4'h9 |=> (stb == 7'h5f)[*5] ##1 stb == 7'h7f
      ##1 (stb == 7'h79)[*6] ##1 (stb == 7'h7a)[*6] ##1 PC_LOAD;
  endproperty
  a_vec: assert property (p_vec)
    else $error("bad vectored response");
  c_load: cover property (DONE && PC_LOAD);
  c_smp: cover property (IRQ_SAMPLE);
  c_io: cover property (!IO_REQUEST_N && !RD_N && FETCH_CYCLE_MARKER_N);
endmodule : cbs_bus_seq_asserts

bind cbs_bus_seq cbs_bus_seq_asserts chk (
  .CLK(CLK), .RST_B(RST_B), .START(START), .OP(OP), .PC_IN(PC_IN),
  .IO_COMPAT_BIT(IO_COMPAT_BIT), .ADDR(ADDR), .DATA_OE(DATA_OE),
  .RD_N(RD_N), .WR_N(WR_N), .MEMORY_REQUEST_N(MEMORY_REQUEST_N),
  .IO_REQUEST_N(IO_REQUEST_N),
  .FETCH_CYCLE_MARKER_N(FETCH_CYCLE_MARKER_N),
  .OPENING_CYCLE_FLAG_N(OPENING_CYCLE_FLAG_N), .HALT_N(HALT_N),
  .BUSY(BUSY), .DONE(DONE), .PC_LOAD(PC_LOAD), .IRQ_SAMPLE(IRQ_SAMPLE),
  .BUS_LOCK(BUS_LOCK));

// ===== verification/cpu_interrupt_and_test_bus_cycles_test.sv
// self-checking bench for the bus-cycle sequencer
`timescale 1ns/1ps
module cpu_interrupt_and_test_bus_cycles_test;
  import cbs_pkg::*;
  logic        CLK = 1'b0, RST_B = 1'b0, START = 1'b0, IO_COMPAT_BIT = 1'b0;
  logic [3:0]  OP = 4'h0, cur;
  logic [15:0] PC_IN = 16'h0, SP_IN = 16'h0, HL_IN = 16'h0;
  logic [7:0]  C_IN = 8'h00, I_IN = 8'h00, VEC_IN = 8'h00, ack_val = 8'h00;
  logic [7:0]  DATA_IN, DATA_OUT, OPERAND, ACK_BYTE;
  logic [15:0] ADDR, PC_OUT, pc, sp, hl, npc;
  logic        DATA_OE, RD_N, WR_N, MEMORY_REQUEST_N, IO_REQUEST_N;
  logic        FETCH_CYCLE_MARKER_N, OPENING_CYCLE_FLAG_N, HALT_N;
  logic        BUSY, DONE, PC_LOAD, IRQ_SAMPLE, BUS_LOCK;
  logic [7:0]  c, iv, ab, opnd;
  logic [31:0] q[$];
  int          n_errors = 0, comparisons = 0;

  cbs_bus_seq dut (
    .CLK(CLK), .RST_B(RST_B), .START(START), .OP(OP), .PC_IN(PC_IN),
    .SP_IN(SP_IN), .HL_IN(HL_IN), .C_IN(C_IN), .I_IN(I_IN),
    .VEC_IN(VEC_IN), .IO_COMPAT_BIT(IO_COMPAT_BIT), .DATA_IN(DATA_IN),
    .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .ADDR(ADDR), .RD_N(RD_N),
    .WR_N(WR_N), .MEMORY_REQUEST_N(MEMORY_REQUEST_N),
    .IO_REQUEST_N(IO_REQUEST_N),
    .FETCH_CYCLE_MARKER_N(FETCH_CYCLE_MARKER_N),
    .OPENING_CYCLE_FLAG_N(OPENING_CYCLE_FLAG_N), .HALT_N(HALT_N),
    .BUSY(BUSY), .DONE(DONE), .PC_LOAD(PC_LOAD), .PC_OUT(PC_OUT),
    .OPERAND(OPERAND), .ACK_BYTE(ACK_BYTE), .IRQ_SAMPLE(IRQ_SAMPLE),
    .BUS_LOCK(BUS_LOCK));
  cbs_bus_partner mdl (.clk(CLK), .addr(ADDR), .rd_n(RD_N),
    .io_request_n(IO_REQUEST_N), .fetch_cycle_marker_n(FETCH_CYCLE_MARKER_N),
    .ack_val(ack_val), .data(DATA_IN));
  initial forever #50 CLK = ~CLK;
////////////////////////////////////////
  function automatic logic [7:0] mb(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction : mb
  // one entry per t-state: {write data, drive, strobes, address}
  task automatic cyc(input logic [6:0] s, input logic [15:0] a, input int n,
                     input logic [7:0] d = 8'h00);
    repeat (n) q.push_back({d, !s[1], s, a});
  endtask : cyc
  task automatic push(input logic [15:0] r);
    cyc(7'h79, sp - 16'h1, 3, r[15:8]);
    cyc(7'h79, sp - 16'h2, 3, r[7:0]);
  endtask : push
  task automatic chk_bus(input logic [31:0] e, input logic b);
    comparisons++;
    if ({DATA_OE ? DATA_OUT : 8'h00, DATA_OE, HALT_N, OPENING_CYCLE_FLAG_N,
         FETCH_CYCLE_MARKER_N, IO_REQUEST_N, MEMORY_REQUEST_N, WR_N, RD_N,
         ADDR, BUSY, BUS_LOCK, IRQ_SAMPLE} !== {e, b, cur > 4'h3, 1'b0}) begin
      n_errors++;
      $display("MISMATCH %0t bus exp %h addr %h", $time, e, ADDR);
    end
  endtask : chk_bus
  task automatic chk_end();
    logic ld;
    ld = cur inside {4'h6, 4'h8, 4'h9};
    comparisons++;
    if ({DONE, BUSY, PC_LOAD, IRQ_SAMPLE} !== {2'b10, ld, cur < 4'h4}
        || (cur inside {4'h1, 4'h2, 4'h3} && OPERAND !== opnd)
        || (cur inside {4'h5, 4'h6, 4'h8, 4'h9} && ACK_BYTE !== ab)) begin
      n_errors++;
      $display("MISMATCH %0t end of op %h", $time, cur);
    end
    @(negedge CLK);
    if (ld && PC_OUT !== npc) begin
      n_errors++;
      $display("MISMATCH %0t new pc %h", $time, PC_OUT);
    end
  endtask : chk_end
////////////////////////////////////////
  task automatic run(input logic [3:0] op, input logic compat,
                     input logic edg);
    cur = op;
    pc = 16'($urandom);
    sp = edg ? 16'h1 : 16'($urandom);
    hl = 16'($urandom);
    c = 8'($urandom);
    iv = 8'($urandom);
    ab = edg ? 8'hff : 8'($urandom);
    opnd = op == 4'h2 ? mb(hl) : op == 4'h3 ? mb({8'h00, c}) : mb(pc + 16'h2);
    npc = {mb({iv, ab + 8'h01}), mb({iv, ab})};
    if (op < 4'h4) begin
      cyc(7'h4a, pc, 3);
      cyc(7'h6a, pc + 16'h1, 3);
    end
    case (op)
      4'h0: cyc(7'h7f, 16'h0, 1);
      4'h1: cyc(7'h7a, pc + 16'h2, 3);
      4'h2: begin
        cyc(7'h7f, 16'h0, 1);
        cyc(7'h7a, hl, 3);
      end
      4'h3: begin
        cyc(7'h7a, pc + 16'h2, 3);
        cyc(compat ? 7'h76 : 7'h66, {8'h00, c}, 3);
      end
      4'h4, 4'h5: begin
        cyc(op[0] ? 7'h47 : 7'h4a, pc, op[0] ? 4 : 3);
        cyc(7'h7f, 16'h0, 2);
        push(pc);
      end
      4'h6: begin
        cyc(7'h47, pc, 5);
        cyc(7'h7a, pc, 3);
        cyc(7'h7a, pc + 16'h1, 3);
        cyc(7'h7f, 16'h0, 1);
        push(pc + 16'h2);
        npc = {mb(pc + 16'h1), mb(pc)};
      end
      4'h7: begin
        cyc(7'h47, pc, 5);
        push(pc);
      end
      default: begin
        cyc(op[0] ? 7'h5f : 7'h47, pc, 5);
        cyc(7'h7f, 16'h0, 1);
        push(pc);
        cyc(7'h7a, {iv, ab}, 3);
        cyc(7'h7a, {iv, ab + 8'h01}, 3);
      end
    endcase
    @(posedge CLK);
    START <= 1'b1;
    OP <= op;
    PC_IN <= pc;
    SP_IN <= sp;
    HL_IN <= hl;
    C_IN <= c;
    I_IN <= iv;
    VEC_IN <= ab;
    ack_val <= ab;
    IO_COMPAT_BIT <= compat;
    @(posedge CLK);
    START <= 1'b0;
    // requests while busy must be ignored and latched values kept
    while (q.size() > 0) begin
      @(negedge CLK);
      chk_bus(q.pop_front(), 1'b1);
      @(posedge CLK);
      START <= q.size() > 0;
      OP <= 4'($urandom);
      PC_IN <= 16'($urandom);
      IO_COMPAT_BIT <= 1'($urandom);
    end
    @(negedge CLK);
    chk_end();
    $display("test op %h done", op);
  endtask : run
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge CLK);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'hd8e70059));
    repeat (6) @(posedge CLK);
    RST_B <= 1'b1;
    @(negedge CLK);
    cur = 4'h0;
    chk_bus({9'h000, 7'h7f, 16'h0}, 1'b0);
    for (int k = 0; k < 30; k++)
      run(4'(k % 10), 1'((k / 10) % 2), k >= 20);
    // abort an interrupt response part way by a second reset
    @(posedge CLK);
    START <= 1'b1;
    OP <= 4'h8;
    @(posedge CLK);
    START <= 1'b0;
    repeat (4) @(posedge CLK);
    RST_B <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_B <= 1'b1;
    @(negedge CLK);
    cur = 4'h0;
    chk_bus({9'h000, 7'h7f, 16'h0}, 1'b0);
    $display("test reset abort done");
    tally_and_finish();
  end
endmodule : cpu_interrupt_and_test_bus_cycles_test
